// >>> can_acceptance_filter.sv
// Purpose: CAN acceptance filtering with receive buffer full and overflow flags
// Assumes: Received identifiers arrive as a one-cycle strobe from the receiver on pclk
// Notes: Registers over APB with one wait state
//
// What this block does
// - Unmasked extended identifier bits 15-0 must equal the filter's stored bits.
// - Mask source 00/01/10 picks mask 0/1/2; 11 selects no mask; the code never lets a filter set to 11 match.
// - Sixteen two-bit mask selectors sit in two registers, filter 15 at top.
// - Standard identifier mask bit one compares that bit, zero ignores it.
// - Extended mask bits 17:16 and 15:0 likewise include or ignore bits.
// - Type mode one: message type must agree with filter's extended select bit.
// - Type mode zero: either type accepted when its identifier bits match.
// - Writing a message into buffer n sets its full flag, 32 flags.
// - Software clears full flags; software can never set them.
// - Directing a message to a still-full buffer sets its overflow flag.
// - Overflow flags reset to zero and are clear-only from software.
// - Mask standard identifier bits 4 and 2 always read zero.
// - Unmasked standard bits and extended 17:16 must match the filter.
// - Under type mode one, extended select set takes extended only, clear standard only.
// - Sixteen filter enables reset to one; only enabled filters accept.
// - Four-bit buffer pointer: 0-14 pick buffers, 1111 picks the receive FIFO.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "can_filter_params.svh"

module can_acceptance_filter
  import can_filter_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received frame from the bit-stream receiver
  input wire logic rx_valid,
  input wire logic rx_ext,
  input wire logic [10:0] rx_sid,
  input wire logic [17:0] rx_eid,
  input wire logic [4:0] fifo_slot,
  // Acceptance result
  output logic accept_q,
  output logic accept_fifo_q,
  output logic [4:0] accept_buf_q,
  output logic [3:0] accept_filter_q,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Register storage
  reg16_t filt_sid_q [16];
  reg16_t filt_eid_q [16];
  reg16_t mask_sid_q [3];
  reg16_t mask_eid_q [3];
  reg16_t bptr_q [4];
  reg16_t msel_lo_q, msel_hi_q, filt_en_q;
  logic [31:0] full_q, full_d, ovf_q, ovf_d;
  logic [1:0] int_stat_q, int_stat_d, int_mask_q;
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ==========================================================
  // APB decode
  logic access, wr_en;
  logic [15:0] wr16;
  logic mapped, fixed_miss;
  logic [31:0] rd_data;
  logic [15:0] wsel_fsid, wsel_feid;
  logic [2:0] wsel_msid, wsel_meid;
  logic [3:0] wsel_bptr;

  assign access = psel & penable;
  // Writes land on the completing edge, when pready is already high
  assign wr_en = access & pready_q & pwrite & mapped;
  assign wr16 = pwdata[15:0];

  always_comb
  begin
    fixed_miss = 1'b0;
    rd_data = 32'h0000_0000;
    wsel_fsid = 16'h0000;
    wsel_feid = 16'h0000;
    wsel_msid = 3'h0;
    wsel_meid = 3'h0;
    wsel_bptr = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (paddr == `FILT_SID_OFF + 12'(i * 4))
      begin
        wsel_fsid[i] = 1'b1;
        rd_data = {16'h0000, filt_sid_q[i]};
      end
      if (paddr == `FILT_EID_OFF + 12'(i * 4))
      begin
        wsel_feid[i] = 1'b1;
        rd_data = {16'h0000, filt_eid_q[i]};
      end
    end
    for (int m = 0; m < 3; m++)
    begin
      if (paddr == `MASK_SID_OFF + 12'(m * 4))
      begin
        wsel_msid[m] = 1'b1;
        rd_data = {16'h0000, mask_sid_q[m] & `SID_REG_IMPL};
      end
      if (paddr == `MASK_EID_OFF + 12'(m * 4))
      begin
        wsel_meid[m] = 1'b1;
        rd_data = {16'h0000, mask_eid_q[m]};
      end
    end
    for (int b = 0; b < 4; b++)
    begin
      if (paddr == `BPTR_OFF + 12'(b * 4))
      begin
        wsel_bptr[b] = 1'b1;
        rd_data = {16'h0000, bptr_q[b]};
      end
    end
    case (paddr)
      `MSEL_LO_OFF: rd_data = {16'h0000, msel_lo_q};
      `MSEL_HI_OFF: rd_data = {16'h0000, msel_hi_q};
      `FILT_EN_OFF: rd_data = {16'h0000, filt_en_q};
      `FULL_LO_OFF: rd_data = {16'h0000, full_q[15:0]};
      `FULL_HI_OFF: rd_data = {16'h0000, full_q[31:16]};
      `OVF_LO_OFF: rd_data = {16'h0000, ovf_q[15:0]};
      `OVF_HI_OFF: rd_data = {16'h0000, ovf_q[31:16]};
      `INT_STAT_OFF: rd_data = {30'h0000_0000, int_stat_q};
      `INT_MASK_OFF: rd_data = {30'h0000_0000, int_mask_q};
      default: fixed_miss = 1'b1;
    endcase
    mapped = ~fixed_miss | (|{wsel_fsid, wsel_feid, wsel_msid, wsel_meid, wsel_bptr});
  end

  // ==========================================================
  // APB answer: one wait state, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      prdata_q <= (access & ~pready_q & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        filt_sid_q[i] <= `ID_RST;
        filt_eid_q[i] <= `ID_RST;
      end
    end
    else if (wr_en)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (wsel_fsid[i]) filt_sid_q[i] <= wr16 & `SID_REG_IMPL;
        if (wsel_feid[i]) filt_eid_q[i] <= wr16;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int m = 0; m < 3; m++)
      begin
        mask_sid_q[m] <= `ID_RST;
        mask_eid_q[m] <= `ID_RST;
      end
    end
    else if (wr_en)
    begin
      for (int m = 0; m < 3; m++)
      begin
        if (wsel_msid[m]) mask_sid_q[m] <= wr16 & `SID_REG_IMPL;
        if (wsel_meid[m]) mask_eid_q[m] <= wr16;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msel_lo_q <= `MSEL_RST;
      msel_hi_q <= `MSEL_RST;
      filt_en_q <= `FILT_EN_RST;
      int_mask_q <= `INT_RST;
      for (int b = 0; b < 4; b++)
        bptr_q[b] <= `BPTR_RST;
    end
    else if (wr_en)
    begin
      if (paddr == `MSEL_LO_OFF) msel_lo_q <= wr16;
      if (paddr == `MSEL_HI_OFF) msel_hi_q <= wr16;
      if (paddr == `FILT_EN_OFF) filt_en_q <= wr16;
      if (paddr == `INT_MASK_OFF) int_mask_q <= pwdata[1:0];
      for (int b = 0; b < 4; b++)
        if (wsel_bptr[b]) bptr_q[b] <= wr16;
    end
  end

  // ==========================================================
  // Filter evaluation, all sixteen in the strobe cycle
  logic [31:0] msel_all;
  logic [63:0] bptr_all;
  logic [15:0] match;
  logic found;
  filt_idx_t win;
  logic [3:0] win_ptr;
  logic [4:0] dest;

  assign msel_all = {msel_hi_q, msel_lo_q};
  assign bptr_all = {bptr_q[3], bptr_q[2], bptr_q[1], bptr_q[0]};

  always_comb
  begin
    mask_src_t src;
    reg16_t msid, meid, fsid, feid;
    logic sid_ok, eid_ok, type_ok;
    src = MASK_0;
    msid = 16'h0000;
    meid = 16'h0000;
    fsid = 16'h0000;
    feid = 16'h0000;
    sid_ok = 1'b0;
    eid_ok = 1'b0;
    type_ok = 1'b0;
    match = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      src = mask_src_t'(msel_all[2 * i +: 2]);
      fsid = filt_sid_q[i];
      feid = filt_eid_q[i];
      case (src)
        MASK_0: begin msid = mask_sid_q[0]; meid = mask_eid_q[0]; end
        MASK_1: begin msid = mask_sid_q[1]; meid = mask_eid_q[1]; end
        MASK_2: begin msid = mask_sid_q[2]; meid = mask_eid_q[2]; end
        default: begin msid = 16'h0000; meid = 16'h0000; end
      endcase
      sid_ok = ((rx_sid ^ fsid[`SID_HI:`SID_LO]) & msid[`SID_HI:`SID_LO]) == 11'h000;
      eid_ok = ((rx_eid[17:16] ^ fsid[1:0]) & msid[1:0]) == 2'h0
        && ((rx_eid[15:0] ^ feid) & meid) == 16'h0000;
      // Type check only when the selected mask asks for it
      type_ok = !msid[`TYPE_BIT] || (rx_ext == fsid[`TYPE_BIT]);
      match[i] = filt_en_q[i] && (src != MASK_RSVD) && type_ok
        && sid_ok && (!rx_ext || eid_ok);
    end
  end

  always_comb
  begin
    found = |match;
    win = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (match[i]) win = 4'(i);
  end

  assign win_ptr = bptr_all[{win, 2'b00} +: 4];
  // FIFO hits land in the slot the buffer manager names
  assign dest = (win_ptr == `FIFO_PTR) ? fifo_slot : {1'b0, win_ptr};

  // ==========================================================
  // Full and overflow flags: hardware set wins over a software clear
  logic hit;
  logic [31:0] hit_vec, clr_full, clr_ovf;

  assign hit = rx_valid & found;
  assign hit_vec = hit ? (32'h0000_0001 << dest) : 32'h0000_0000;
  assign clr_full = {(wr_en && paddr == `FULL_HI_OFF) ? wr16 : 16'h0000,
                     (wr_en && paddr == `FULL_LO_OFF) ? wr16 : 16'h0000};
  assign clr_ovf = {(wr_en && paddr == `OVF_HI_OFF) ? wr16 : 16'h0000,
                    (wr_en && paddr == `OVF_LO_OFF) ? wr16 : 16'h0000};
  assign full_d = (full_q & ~clr_full) | hit_vec;
  assign ovf_d = (ovf_q & ~clr_ovf) | (hit_vec & full_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_q <= {`FLAG_RST, `FLAG_RST};
      ovf_q <= {`FLAG_RST, `FLAG_RST};
    end
    else
    begin
      full_q <= full_d;
      ovf_q <= ovf_d;
    end
  end

  // ==========================================================
  // Acceptance report
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accept_q <= 1'b0;
      accept_fifo_q <= 1'b0;
      accept_buf_q <= 5'h00;
      accept_filter_q <= 4'h0;
    end
    else
    begin
      accept_q <= hit;
      accept_fifo_q <= hit && (win_ptr == `FIFO_PTR);
      if (hit)
      begin
        accept_buf_q <= dest;
        accept_filter_q <= win;
      end
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  logic [1:0] int_set, int_clr;

  assign int_set = {|(hit_vec & full_q), hit};
  assign int_clr = (wr_en && paddr == `INT_STAT_OFF) ? pwdata[1:0] : 2'h0;
  assign int_stat_d = (int_stat_q & ~int_clr) | int_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_stat_q <= `INT_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_d & int_mask_q);
    end
  end

endmodule
`default_nettype wire

// >>> can_filter_params.svh
// Purpose: Offsets, field positions, reset values for the acceptance filter block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef CAN_FILTER_PARAMS_SVH
`define CAN_FILTER_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define FILT_SID_OFF 12'h000
`define FILT_EID_OFF 12'h040
`define MSEL_LO_OFF 12'h080
`define MSEL_HI_OFF 12'h084
`define MASK_SID_OFF 12'h090
`define MASK_EID_OFF 12'h0a0
`define FILT_EN_OFF 12'h0b0
`define BPTR_OFF 12'h0c0
`define FULL_LO_OFF 12'h0d0
`define FULL_HI_OFF 12'h0d4
`define OVF_LO_OFF 12'h0d8
`define OVF_HI_OFF 12'h0dc
`define INT_STAT_OFF 12'h0e0
`define INT_MASK_OFF 12'h0e4

// ==========================================================
// Field positions and implemented bits
`define SID_HI 15
`define SID_LO 5
`define TYPE_BIT 3
`define SID_REG_IMPL 16'hffeb
`define FIFO_PTR 4'hf
`define INT_ACCEPT_BIT 0
`define INT_OVF_BIT 1

// ==========================================================
// Reset values
`define ID_RST 16'h0000
`define MSEL_RST 16'h0000
`define FILT_EN_RST 16'hffff
`define BPTR_RST 16'h0000
`define FLAG_RST 16'h0000
`define INT_RST 2'h0

`endif

// >>> can_filter_pkg.sv
// Purpose: Types shared by the acceptance filter block
// Assumes: Constants live in can_filter_params.svh
// Notes: Types only
`default_nettype none
package can_filter_pkg;
  typedef enum logic [1:0] {
    MASK_0 = 2'b00,
    MASK_1 = 2'b01,
    MASK_2 = 2'b10,
    MASK_RSVD = 2'b11
  } mask_src_t;
  typedef logic [15:0] reg16_t;
  typedef logic [3:0] filt_idx_t;
endpackage
`default_nettype wire

// >>> can_filter_monitor.sv
// Purpose: Port assertions for the acceptance filter
// Assumes: APB answer after one wait state
// Notes: Bound to every filter instance below
`timescale 1ns/1ps
`default_nettype none
module can_filter_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frames
  input wire logic rx_valid,
  input wire logic [4:0] fifo_slot,
  input wire logic accept_q,
  input wire logic accept_fifo_q,
  input wire logic [4:0] accept_buf_q
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====
  // Bus
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  a_one_wait: assert property (s_first_access |=> pready)
    else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata outside read answer");
  // ====
  // Frames
  a_accept_cause: assert property (accept_q |-> $past(rx_valid))
    else $error("accept without frame");
  a_fifo_dest: assert property (accept_fifo_q |-> accept_q && accept_buf_q == $past(fifo_slot))
    else $error("fifo accept to wrong slot");
  a_ptr_range: assert property (accept_q && !accept_fifo_q |-> accept_buf_q <= 5'h0e)
    else $error("buffer pointer out of range");
  a_dest_hold: assert property (!accept_q |-> $stable(accept_buf_q))
    else $error("destination moved without accept");
endmodule

bind can_acceptance_filter can_filter_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .fifo_slot(fifo_slot), .accept_q(accept_q), .accept_fifo_q(accept_fifo_q),
  .accept_buf_q(accept_buf_q)
);
`default_nettype wire

// >>> can_frame_source.sv
// Purpose: Remote nodes feeding received identifiers
// Assumes: One identifier per rx_valid pulse on pclk
// Notes: Idle lines carry the inverse of the last frame
`timescale 1ns/1ps
`default_nettype none
module can_frame_source (
  // Clock
  input wire logic pclk,
  // Received frame
  output logic rx_valid,
  output logic rx_ext,
  output logic [10:0] rx_sid,
  output logic [17:0] rx_eid,
  output logic [4:0] fifo_slot
);
  initial
  begin
    rx_valid = 1'b0;
    rx_ext = 1'b0;
    rx_sid = 11'h0;
    rx_eid = 18'h0;
    fifo_slot = 5'h0;
  end
  // ====
  // One frame, taken at the second edge
  task automatic send(input logic e, input logic [10:0] s, input logic [17:0] x, input logic [4:0] f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_ext <= e;
    rx_sid <= s;
    rx_eid <= x;
    fifo_slot <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Stale ids must not look like the frame just sent
    rx_ext <= ~e;
    rx_sid <= ~s;
    rx_eid <= ~x;
    fifo_slot <= ~f;
  endtask
endmodule
`default_nettype wire

// >>> can_acceptance_filter_tb.sv
// Purpose: Self-checking bench for the acceptance filter
// Assumes: Partner model drives the frame inputs
// Notes: APB answers are awaited, never counted
`timescale 1ns/1ps
`default_nettype none
`include "can_filter_params.svh"
module can_acceptance_filter_tb
  import can_filter_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ext, accept_q, accept_fifo_q, irq;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  logic [4:0] fifo_slot, accept_buf_q;
  logic [3:0] accept_filter_q;
  int n_errors = 0;
  int num_checks = 0;
  always #2 pclk = ~pclk;
  can_acceptance_filter i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_sid(rx_sid), .rx_eid(rx_eid),
    .fifo_slot(fifo_slot), .accept_q(accept_q), .accept_fifo_q(accept_fifo_q),
    .accept_buf_q(accept_buf_q), .accept_filter_q(accept_filter_q), .irq(irq)
  );
  can_frame_source i_src (
    .pclk(pclk), .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_sid(rx_sid),
    .rx_eid(rx_eid), .fifo_slot(fifo_slot)
  );
  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ====
  // APB master, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge pclk);
    if (i == 20)
    begin
      n_errors++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic irq_is(input logic x);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, x});
  endtask
  // Kind 0 none, 1 buffer, 2 fifo; fifo hits always use slot 20
  task automatic fr(input logic e, input logic [10:0] s, input logic [17:0] x,
                    input logic [1:0] k, input logic [4:0] b, input logic [3:0] f);
    i_src.send(e, s, x, 5'd20);
    #1;
    chk({31'h0, accept_q}, {31'h0, k != 2'd0});
    chk({31'h0, accept_fifo_q}, {31'h0, k[1]});
    if (k != 2'd0)
    begin
      chk({27'h0, accept_buf_q}, {27'h0, b});
      chk({28'h0, accept_filter_q}, {28'h0, f});
    end
    @(posedge pclk);
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    rc(`FILT_EN_OFF, 32'hffff);
    rc(`MSEL_HI_OFF, 32'h0);
    rc(`FULL_HI_OFF, 32'h0);
    rc(`OVF_LO_OFF, 32'h0);
    wr(`MASK_SID_OFF, 32'hffffffff);
    rc(`MASK_SID_OFF, 32'hffeb);
  endtask
  task automatic t_route();
    wr(`FILT_EN_OFF, 32'h6);
    wr(`FILT_SID_OFF + 12'h4, 32'h2460);
    wr(`MASK_SID_OFF + 12'h4, 32'hffe0);
    wr(`MSEL_LO_OFF, 32'h24);
    wr(`BPTR_OFF, 32'h0f30);
    fr(1'b0, 11'h123, 18'h0, 2'd1, 5'd3, 4'd1);
    fr(1'b0, 11'h122, 18'h0, 2'd2, 5'd20, 4'd2);
    rc(`FULL_LO_OFF, 32'h8);
    rc(`FULL_HI_OFF, 32'h10);
    fr(1'b0, 11'h123, 18'h0, 2'd1, 5'd3, 4'd1);
    rc(`OVF_LO_OFF, 32'h8);
    rc(`OVF_HI_OFF, 32'h0);
  endtask
  task automatic t_clear();
    irq_is(1'b0);
    wr(`INT_MASK_OFF, 32'h2);
    irq_is(1'b1);
    wr(`INT_STAT_OFF, 32'h3);
    irq_is(1'b0);
    rc(`INT_STAT_OFF, 32'h0);
    wr(`FULL_LO_OFF, 32'hfff7);
    rc(`FULL_LO_OFF, 32'h8);
    wr(`FULL_LO_OFF, 32'h8);
    rc(`FULL_LO_OFF, 32'h0);
    wr(`OVF_LO_OFF, 32'hffff);
    rc(`OVF_LO_OFF, 32'h0);
  endtask
  task automatic t_ext();
    wr(`FILT_EN_OFF, 32'h2);
    wr(`FILT_SID_OFF + 12'h4, 32'h2469);
    wr(`FILT_EID_OFF + 12'h4, 32'ha5a5);
    wr(`MASK_SID_OFF + 12'h4, 32'hffeb);
    wr(`MASK_EID_OFF + 12'h4, 32'hffff);
    fr(1'b1, 11'h123, 18'h1a5a5, 2'd1, 5'd3, 4'd1);
    fr(1'b1, 11'h123, 18'h1a5a4, 2'd0, 5'd0, 4'd0);
    fr(1'b1, 11'h123, 18'h0a5a5, 2'd0, 5'd0, 4'd0);
    fr(1'b0, 11'h123, 18'h1a5a5, 2'd0, 5'd0, 4'd0);
    wr(`MASK_SID_OFF + 12'h4, 32'hffe3);
    fr(1'b0, 11'h123, 18'h0, 2'd1, 5'd3, 4'd1);
    wr(`MSEL_LO_OFF, {28'h0, MASK_RSVD, 2'b00});
    fr(1'b0, 11'h123, 18'h0, 2'd0, 5'd0, 4'd0);
    wr(`MSEL_LO_OFF, 32'h4);
    wr(`FILT_EN_OFF, 32'h0);
    fr(1'b0, 11'h123, 18'h0, 2'd0, 5'd0, 4'd0);
  endtask
  task automatic t_high();
    wr(`FILT_EN_OFF, 32'h8000);
    wr(`FILT_SID_OFF + 12'h3c, 32'h2460);
    wr(`MSEL_HI_OFF, 32'h4000);
    wr(`BPTR_OFF + 12'hc, 32'he000);
    fr(1'b0, 11'h123, 18'h0, 2'd1, 5'd14, 4'd15);
    wr(`MSEL_HI_OFF, 32'h0);
    fr(1'b1, 11'h123, 18'h0, 2'd0, 5'd0, 4'd0);
    fr(1'b0, 11'h123, 18'h0, 2'd1, 5'd14, 4'd15);
    rc(`FULL_LO_OFF, 32'h4008);
    rc(`OVF_LO_OFF, 32'h4008);
    // Reset in mid-run must clear the low full and overflow flags again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`FULL_LO_OFF, 32'h0);
    rc(`OVF_LO_OFF, 32'h0);
    rc(`FILT_EN_OFF, 32'hffff);
  endtask
  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'hffc, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_route();
    t_clear();
    t_ext();
    t_high();
    t_unmapped();
    finish_test();
  end
endmodule
`default_nettype wire
